// [scp_port.sv]
// serial configuration port with register array, sampled serial clock
`timescale 1ns/1ps
`default_nettype none
module scp_port #(
   parameter int NREG = scp_pkg::NUM_REGS // number of registers
) (
   input  wire logic       SYS_CLK,        // system clock
   input  wire logic       RESET,          // synchronous active high reset
   input  wire logic       SCLK,           // serial clock pin
   input  wire logic       PORT_SELECT_N,  // active low frame select
   input  wire logic       SDIO_IN,        // shared data pin, input side
   output logic            SDIO_OUT,       // shared data pin, output value
   output logic            SDIO_OE,        // shared data pin, drive enable
   output logic            SERIAL_DATA_OUT,    // dedicated output pin value
   output logic            SERIAL_DATA_OUT_OE, // dedicated output drive enable
   output logic            BIDIR_PIN_SELECT,   // config: shared pin mode
   output logic            BIT_ORDER_SELECT,   // config: lsb first
   output logic [7:0]      WR_DATA,        // last written byte
   output logic [4:0]      WR_ADDR,        // last written address
   output logic            WR_STROBE       // one cycle per written byte
);
   // refuse register counts that the 5-bit address cannot serve
   if (NREG < 1 || NREG > scp_pkg::NUM_REGS) begin : g_nreg_bad
      $error("NREG must be 1..32");
   end
   // three-stage samplers; stage 1 feeds only stage 2
   logic [2:0] sclk_sync_reg, sel_sync_reg, din_sync_reg; // samplers
   logic sclk_lvl_reg, sel_lvl_reg;                        // accepted levels
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         sclk_sync_reg <= 3'h0;
         sel_sync_reg  <= 3'h7;
         din_sync_reg  <= 3'h0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], SCLK};
         sel_sync_reg  <= {sel_sync_reg[1:0], PORT_SELECT_N};
         din_sync_reg  <= {din_sync_reg[1:0], SDIO_IN};
      end
   end
   // a level change is accepted once stages 2 and 3 agree
   wire sclk_agree = sclk_sync_reg[1] == sclk_sync_reg[2];
   wire sel_agree  = sel_sync_reg[1] == sel_sync_reg[2];
   wire sclk_next  = sclk_agree ? sclk_sync_reg[2] : sclk_lvl_reg;
   wire sel_next   = sel_agree ? sel_sync_reg[2] : sel_lvl_reg;
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         sclk_lvl_reg <= 1'b0;
         sel_lvl_reg  <= 1'b1;
      end else begin
         sclk_lvl_reg <= sclk_next;
         sel_lvl_reg  <= sel_next;
      end
   end
   wire rise     = sclk_next & ~sclk_lvl_reg; // sample edge
   wire fall     = ~sclk_next & sclk_lvl_reg; // drive edge
   wire sel_act  = ~sel_lvl_reg;
   wire din      = din_sync_reg[2];           // data aligned with sclk path

   // register array; every entry readable and writable
   logic [7:0] regs_reg [NREG];
   scp_pkg::scp_state_t state_reg, state_next; // sequencer
   logic [7:0] shift_reg;         // incoming bits
   logic [2:0] bitcnt_reg;        // bit within current byte
   logic [1:0] bytes_left_reg;    // remaining data bytes minus one
   logic       rd_reg;            // current cycle is a read
   logic [4:0] addr_reg;          // current register address
   logic [7:0] tx_reg;            // outgoing byte
   logic       dout_reg;          // outgoing bit, changes on fall
   logic       out_en_reg;        // output window active

   wire cfg_lsb   = regs_reg[scp_pkg::CFG_REG][scp_pkg::CFG_LSB];
   wire cfg_bidir = regs_reg[scp_pkg::CFG_REG][scp_pkg::CFG_BIDIR];
   // byte assembled including current bit, honouring order
   wire [7:0] byte_in = cfg_lsb ? {din, shift_reg[7:1]} : {shift_reg[6:0], din};
   wire last_bit  = bitcnt_reg == scp_pkg::BIT_LAST;
   wire byte_done = rise & last_bit;
   // next address: msb first counts down, lsb first counts up
   wire [4:0] addr_step = cfg_lsb ? addr_reg + 5'h01 : addr_reg - 5'h01;
   wire [4:0] ins_addr  = byte_in[scp_pkg::CMD_ADR_HI:0];
   wire       wr_fire   = (state_reg == scp_pkg::SCP_DATA) & byte_done & ~rd_reg
                          & sel_act;
   function automatic logic [7:0] rd_reg_val(input logic [4:0] a);
      rd_reg_val = (a < NREG) ? regs_reg[a] : 8'h00;
   endfunction

   // sequencer transitions; select high always returns to idle
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         scp_pkg::SCP_IDLE: begin
            if (sel_act) state_next = scp_pkg::SCP_INSTR;
         end
         scp_pkg::SCP_INSTR: begin
            if (byte_done) state_next = scp_pkg::SCP_DATA;
         end
         scp_pkg::SCP_DATA: begin
            // exact byte count then stop
            if (byte_done && bytes_left_reg == 2'h0) state_next = scp_pkg::SCP_DONE;
         end
         scp_pkg::SCP_DONE: state_next = scp_pkg::SCP_DONE;
         default: state_next = scp_pkg::SCP_IDLE;
      endcase
      if (!sel_act) state_next = scp_pkg::SCP_IDLE;
   end

   // shift and decode; partial bytes die with the frame
   always_ff @(posedge SYS_CLK) begin
      if (RESET || !sel_act) begin
         shift_reg  <= 8'h00;
         bitcnt_reg <= 3'h0;
      end else if (rise) begin
         shift_reg  <= byte_in;        // sample on rising edge
         bitcnt_reg <= bitcnt_reg + 3'h1;
      end
   end
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         state_reg      <= scp_pkg::SCP_IDLE;
         rd_reg         <= 1'b0;
         addr_reg       <= 5'h00;
         bytes_left_reg <= 2'h0;
      end else begin
         state_reg <= state_next;
         if (state_reg == scp_pkg::SCP_INSTR && byte_done && sel_act) begin
            // decode direction, count, address
            rd_reg         <= byte_in[scp_pkg::CMD_RD_BIT];
            bytes_left_reg <= byte_in[scp_pkg::CMD_CNT_HI:scp_pkg::CMD_CNT_LO];
            addr_reg       <= ins_addr;
         end else if (state_reg == scp_pkg::SCP_DATA && byte_done) begin
            bytes_left_reg <= bytes_left_reg - 2'h1;
            addr_reg       <= addr_step;
         end
      end
   end
   // write lands with the byte's last bit, not at frame end
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         for (int i = 0; i < NREG; i++) regs_reg[i] <= scp_pkg::REG_RESET;
      end else if (wr_fire && addr_reg < NREG) begin
         regs_reg[addr_reg] <= byte_in;
      end
   end
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         WR_STROBE <= 1'b0;
         WR_DATA   <= 8'h00;
         WR_ADDR   <= 5'h00;
      end else begin
         WR_STROBE <= wr_fire;
         if (wr_fire) begin
            WR_DATA <= byte_in;
            WR_ADDR <= addr_reg;
         end
      end
   end
   // read path: load byte at instruction end and each byte end
   wire tx_first = ~cfg_lsb ? tx_reg[7] : tx_reg[0];
   always_ff @(posedge SYS_CLK) begin
      if (RESET || !sel_act) begin
         tx_reg     <= 8'h00;
         dout_reg   <= 1'b0;
         out_en_reg <= 1'b0;
      end else begin
         if (state_reg == scp_pkg::SCP_INSTR && byte_done) begin
            tx_reg     <= rd_reg_val(ins_addr);
            out_en_reg <= byte_in[scp_pkg::CMD_RD_BIT];
         end else if (state_reg == scp_pkg::SCP_DATA && byte_done) begin
            tx_reg     <= rd_reg_val(addr_step);
            if (bytes_left_reg == 2'h0) out_en_reg <= 1'b0;
         end else if (fall && out_en_reg) begin
            // drive on falling edge, then move to next bit
            dout_reg <= tx_first;
            tx_reg   <= cfg_lsb ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
         end
      end
   end
   // pin drivers: released when select high, dedicated pin off in shared mode
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         SDIO_OUT           <= 1'b0;
         SDIO_OE            <= 1'b0;
         SERIAL_DATA_OUT    <= 1'b0;
         SERIAL_DATA_OUT_OE <= 1'b0;
         BIDIR_PIN_SELECT   <= 1'b0;
         BIT_ORDER_SELECT   <= 1'b0;
      end else begin
         SDIO_OUT           <= dout_reg;
         SDIO_OE            <= sel_act & cfg_bidir & out_en_reg & rd_reg;
         SERIAL_DATA_OUT    <= dout_reg;
         SERIAL_DATA_OUT_OE <= sel_act & ~cfg_bidir;
         BIDIR_PIN_SELECT   <= cfg_bidir;
         BIT_ORDER_SELECT   <= cfg_lsb;
      end
   end

   // checks
   instr_len_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (state_reg == scp_pkg::SCP_INSTR && byte_done && sel_act)
      |=> state_reg == scp_pkg::SCP_DATA) else $error("instr not 8 bits");
   abort_idle_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      !sel_act |=> state_reg == scp_pkg::SCP_IDLE) else $error("no restart");
   abort_nowr_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      !sel_act |=> !WR_STROBE) else $error("write while deselected");
   wr_strobe_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      wr_fire |=> WR_STROBE && WR_DATA == $past(byte_in)) else $error("write lost");
   hiz_sel_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      $past(sel_lvl_reg) |-> !SDIO_OE && !SERIAL_DATA_OUT_OE) else $error("drive when off");
   bidir_off_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      $past(cfg_bidir) |-> !SERIAL_DATA_OUT_OE) else $error("dedicated pin on");
   addr_step_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (state_reg == scp_pkg::SCP_DATA && byte_done && sel_act && !cfg_lsb)
      |=> addr_reg == $past(addr_reg) - 5'h01) else $error("msb addr step");
   count_end_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (state_reg == scp_pkg::SCP_DATA && byte_done && sel_act && bytes_left_reg == 2'h0)
      |=> state_reg == scp_pkg::SCP_DONE) else $error("byte count");
   decode_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (state_reg == scp_pkg::SCP_INSTR && byte_done && sel_act)
      |=> rd_reg == $past(byte_in[7]) && addr_reg == $past(byte_in[4:0]))
      else $error("decode");
   write_c: cover property (@(posedge SYS_CLK) wr_fire);
   read_c:  cover property (@(posedge SYS_CLK) SDIO_OE);
   multi_c: cover property (@(posedge SYS_CLK) wr_fire ##[1:200] wr_fire);
   cut_c:   cover property (@(posedge SYS_CLK) state_reg == scp_pkg::SCP_DATA && !sel_act);
   extra_c: cover property (@(posedge SYS_CLK) state_reg == scp_pkg::SCP_DONE && rise);
endmodule
`default_nettype wire

// [scp_pkg.sv]
// package for the serial configuration port: constants, fields and states
// Operation
// - first eight rising edges shift instruction byte
// - decode direction, byte count, start address
// - select high then low restarts instruction phase
// - aborted partial byte writes nothing
// - data phase moves one to four bytes
// - write lands at each byte's last bit
// - shared pin or separate in/out pins
// - msb first or lsb first ordering
// - every register readable and writable
// - bit7 read, bits6-5 count, bits4-0 address
// - sample on rising, drive on falling
// - address decrements msb first, increments lsb first
// - outputs released while select high
package scp_pkg;
   localparam int ADDR_W      = 5;      // register address width
   localparam int NUM_REGS    = 32;     // registers reachable
   localparam int CMD_RD_BIT  = 7;      // read/write bit position
   localparam int CMD_CNT_HI  = 6;      // byte_count_hi position
   localparam int CMD_CNT_LO  = 5;      // byte_count_lo position
   localparam int CMD_ADR_HI  = 4;      // top address bit
   localparam int CFG_REG     = 0;      // register holding port config
   localparam int CFG_BIDIR   = 7;      // bidir_pin_select bit
   localparam int CFG_LSB     = 6;      // bit_order_select bit
   localparam logic [7:0] REG_RESET = 8'h00; // reset value of every register
   localparam logic [2:0] BIT_LAST  = 3'h7;  // last bit index in a byte
   typedef enum logic [1:0] {
      SCP_IDLE = 2'b00,   // select high, waiting
      SCP_INSTR = 2'b01,  // shifting instruction byte
      SCP_DATA = 2'b10,   // moving data bytes
      SCP_DONE = 2'b11    // all bytes moved, ignore further edges
   } scp_state_t;
endpackage

// [scp_master.sv]
// serial master model for the configuration port
`timescale 1ns/1ps
`default_nettype none
module scp_master (
   input  wire logic SYS_CLK,            // system clock
   output logic      SCLK,               // serial clock, still outside frames
   output logic      PORT_SELECT_N,      // frame select, active low
   output logic      SDIO_IN,            // shared pin level
   input  wire logic SDIO_OUT,           // device shared pin value
   input  wire logic SDIO_OE,            // device shared pin enable
   input  wire logic SERIAL_DATA_OUT,    // device dedicated pin value
   input  wire logic SERIAL_DATA_OUT_OE  // device dedicated pin enable
);
   logic mosi; // master bit, flipped on release so stale data never matches
   // device wins the shared pin while it drives
   assign SDIO_IN = SDIO_OE ? SDIO_OUT : mosi;
   initial begin
      SCLK = 1'b0;
      PORT_SELECT_N = 1'b1;
      mosi = 1'b0;
   end
   // n bits of one unit, changed while the clock is low, read at the rise
   task automatic shift(input logic [7:0] tx, input logic lsb, input int n,
                        output logic [7:0] rx);
      int k;
      rx = 8'h00;
      for (int i = 0; i < n; i++) begin
         k = lsb ? i : 7 - i;
         @(posedge SYS_CLK) SCLK <= 1'b0;
         mosi <= tx[k];
         repeat (8) @(posedge SYS_CLK);
         SCLK <= 1'b1;
         rx[k] = SDIO_OE ? SDIO_OUT : (SERIAL_DATA_OUT_OE ? SERIAL_DATA_OUT : ~mosi);
         repeat (7) @(posedge SYS_CLK);
      end
   endtask
   // select low, then a short settle before the first edge
   task automatic open_f();
      @(posedge SYS_CLK) PORT_SELECT_N <= 1'b0;
      repeat (4) @(posedge SYS_CLK);
   endtask
   // select high long enough for a fresh frame
   task automatic close_f();
      @(posedge SYS_CLK) PORT_SELECT_N <= 1'b1;
      SCLK <= 1'b0;
      mosi <= ~mosi;
      repeat (8) @(posedge SYS_CLK);
   endtask
endmodule
`default_nettype wire

// [scp_port_tb.sv]
// self-checking bench for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module scp_port_tb;
   logic SYS_CLK = 1'b0; // 4 ns clock
   logic RESET = 1'b1;   // synchronous reset
   wire logic SCLK, PORT_SELECT_N, SDIO_IN, SDIO_OUT, SDIO_OE;
   wire logic SERIAL_DATA_OUT, SERIAL_DATA_OUT_OE, BIDIR_PIN_SELECT;
   wire logic BIT_ORDER_SELECT, WR_STROBE;
   wire logic [7:0] WR_DATA;
   wire logic [4:0] WR_ADDR;
   logic [12:0] wq[$]; // written address and data
   int rq[$];          // serial rise count at each write
   int rises = 0, error_cnt = 0, n_tests = 0, cyc = 0, sdo_bad = 0;
   always #2 SYS_CLK = ~SYS_CLK;
   scp_port i_dut (.SYS_CLK(SYS_CLK), .RESET(RESET), .SCLK(SCLK),
      .PORT_SELECT_N(PORT_SELECT_N), .SDIO_IN(SDIO_IN), .SDIO_OUT(SDIO_OUT),
      .SDIO_OE(SDIO_OE), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
      .SERIAL_DATA_OUT_OE(SERIAL_DATA_OUT_OE), .BIDIR_PIN_SELECT(BIDIR_PIN_SELECT),
      .BIT_ORDER_SELECT(BIT_ORDER_SELECT), .WR_DATA(WR_DATA), .WR_ADDR(WR_ADDR),
      .WR_STROBE(WR_STROBE));
   scp_master i_mst (.SYS_CLK(SYS_CLK), .SCLK(SCLK), .PORT_SELECT_N(PORT_SELECT_N),
      .SDIO_IN(SDIO_IN), .SDIO_OUT(SDIO_OUT), .SDIO_OE(SDIO_OE),
      .SERIAL_DATA_OUT(SERIAL_DATA_OUT), .SERIAL_DATA_OUT_OE(SERIAL_DATA_OUT_OE));
   // rises counted per frame; select high clears the count
   always @(posedge SCLK or posedge PORT_SELECT_N) rises <= PORT_SELECT_N ? 0 : rises + 1;
   // log writes and dedicated-pin drive in shared mode
   always @(posedge SYS_CLK) begin
      cyc <= cyc + 1;
      if (WR_STROBE === 1'b1) begin
         wq.push_back({WR_ADDR, WR_DATA});
         rq.push_back(rises);
      end
      if (SERIAL_DATA_OUT_OE !== 1'b0 && BIDIR_PIN_SELECT === 1'b1) sdo_bad <= sdo_bad + 1;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [12:0] seen, input logic [12:0] exp, input string m);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %0t %s seen %h want %h", $time, m, seen, exp);
      end
   endtask
   // one whole frame: instruction byte then n data bytes
   task automatic xfer(input logic rd, input logic [4:0] a, input int n,
                       input logic lsb, input logic [31:0] d, output logic [31:0] r);
      logic [7:0] x;
      i_mst.open_f();
      i_mst.shift({rd, 2'(n - 1), a}, lsb, 8, x);
      // one multibyte frame rather than several single ones
      for (int j = 0; j < n; j++) begin
         i_mst.shift(rd ? 8'h55 : d[8*j +: 8], lsb, 8, x);
         r[8*j +: 8] = x;
      end
      i_mst.close_f();
      chk(13'({SDIO_OE, SERIAL_DATA_OUT_OE}), 13'h0000, "drivers released");
   endtask
   // write and judge address, data and the moment of each write
   task automatic wr_chk(input logic [4:0] a, input int n, input logic lsb,
                         input logic [31:0] d);
      logic [31:0] r;
      logic [4:0] e;
      wq.delete();
      rq.delete();
      xfer(1'b0, a, n, lsb, d, r);
      chk(13'(wq.size()), 13'(n), "write count");
      for (int j = 0; j < n && j < wq.size(); j++) begin
         e = lsb ? a + 5'(j) : a - 5'(j);
         chk(wq[j], {e, d[8*j +: 8]}, "write addr data");
         chk(13'(rq[j]), 13'(8 * (j + 2)), "write timing");
      end
   endtask
   task automatic rd_chk(input logic [4:0] a, input int n, input logic lsb,
                         input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, n, lsb, 32'h0, r);
      for (int j = 0; j < n; j++) chk(13'(r[8*j +: 8]), 13'(d[8*j +: 8]), "read");
   endtask
   // all single-bit outputs quiet once reset is gone
   task automatic reset_chk();
      logic [6:0] q;
      q = {SDIO_OE, SERIAL_DATA_OUT_OE, SDIO_OUT, SERIAL_DATA_OUT, WR_STROBE,
           BIDIR_PIN_SELECT, BIT_ORDER_SELECT};
      chk(13'(q), 13'h0000, "reset");
   endtask
   // frames cut inside the instruction and inside a data byte write nothing
   task automatic abort_chk();
      logic [7:0] x;
      wq.delete();
      i_mst.open_f();
      i_mst.shift(8'h00, 1'b0, 5, x); // cut inside the instruction
      i_mst.close_f();
      i_mst.open_f();
      i_mst.shift(8'h09, 1'b0, 8, x);
      i_mst.shift(8'hFF, 1'b0, 4, x); // cut inside the data byte
      i_mst.close_f();
      chk(13'(wq.size()), 13'h0000, "aborted write");
   endtask
   // a byte beyond the requested count is ignored
   task automatic extra_chk();
      logic [7:0] x;
      wq.delete();
      i_mst.open_f();
      i_mst.shift(8'h08, 1'b0, 8, x);
      i_mst.shift(8'h11, 1'b0, 8, x);
      i_mst.shift(8'h22, 1'b0, 8, x); // surplus edges
      i_mst.close_f();
      chk(13'(wq.size()), 13'h0001, "extra edges");
      chk(wq.size() > 0 ? wq[0] : 13'h1FFF, 13'h0811, "single write");
   endtask
   // config write switches pin use and bit order at once
   task automatic cfg_chk();
      wr_chk(5'h00, 1, 1'b0, 32'hC0);
      chk(13'({BIDIR_PIN_SELECT, BIT_ORDER_SELECT}), 13'h0003, "config");
   endtask
   // lsb-first traffic on the shared pin; dedicated pin never driven
   task automatic shared_chk();
      wr_chk(5'h1E, 2, 1'b1, 32'h3C5A);
      rd_chk(5'h1E, 2, 1'b1, 32'h3C5A);
      chk(13'(sdo_bad), 13'h0000, "dedicated pin idle");
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge SYS_CLK);
      RESET <= 1'b0;
      repeat (6) @(posedge SYS_CLK);
      reset_chk();
      wr_chk(5'h05, 4, 1'b0, 32'hD4C3B2A1);
      rd_chk(5'h05, 3, 1'b0, 32'h00C3B2A1);
      abort_chk();
      extra_chk();
      rd_chk(5'h09, 2, 1'b0, 32'h00001100);
      cfg_chk();
      shared_chk();
      tally_and_finish();
   end
endmodule
`default_nettype wire
